// File: rtl/dbk_pkg.sv
// package: constants and types of the key-unlock debugger sequencer
package dbk_pkg;

    // ==========================================================
    // device access-layer register map (control/status space)
    localparam logic [3:0]  CS_KEY_STATUS   = 4'h7;
    localparam logic [3:0]  CS_RESET_REQ    = 4'h8;
    localparam logic [3:0]  CS_SYS_CTRL     = 4'hA;
    localparam logic [3:0]  CS_SYS_STATUS   = 4'hB;
    localparam logic [7:0]  RESET_SIGNATURE = 8'h59;
    localparam logic [7:0]  RESET_RELEASE   = 8'h00;
    localparam logic [7:0]  USER_ROW_KEY_BIT   = 8'h20;
    localparam logic [7:0]  USER_ROW_FINAL_BIT = 8'h02;
    localparam int          LOCKED_POS      = 0;
    localparam int          ROW_PROG_POS    = 2;
    localparam int          NVM_PROG_POS    = 3;

    // ==========================================================
    // key signatures and info block sizes
    localparam logic [63:0] KEY_ERASE    = 64'h4E564D4572617365;
    localparam logic [63:0] KEY_PROGRAM  = 64'h4E564D50726F6720;
    localparam logic [63:0] KEY_USER_ROW = 64'h4E564D5573267465;
    localparam logic [7:0]  INFO_FULL_BYTES   = 8'h10;
    localparam logic [7:0]  INFO_FAMILY_BYTES = 8'h08;
    localparam logic [5:0]  ROW_LAST_BYTE     = 6'h3F;

    // ==========================================================
    // controller register map (word index = byte offset / 4)
    localparam logic [5:0]  REG_CTRL      = 6'h00;
    localparam logic [5:0]  REG_STATUS    = 6'h01;
    localparam logic [5:0]  REG_NVM_WRITE = 6'h02;
    localparam logic [5:0]  REG_SYS_COPY  = 6'h03;
    localparam logic [5:0]  REG_INFO_BASE = 6'h04;
    localparam logic [5:0]  REG_ROW_BASE  = 6'h10;
    localparam int          ST_BUSY_POS   = 0;
    localparam int          ST_DONE_POS   = 1;
    localparam int          ST_READY_POS  = 2;

    // ==========================================================
    // types
    typedef enum logic [2:0] {
        CMD_NONE, CMD_INFO_FULL, CMD_INFO_FAMILY, CMD_ERASE,
        CMD_PROG_ENTER, CMD_PROG_FINISH, CMD_USER_ROW
    } dbk_cmd_e;

    typedef enum logic [2:0] {
        OP_KEY, OP_INFO, OP_CS_STORE, OP_CS_LOAD, OP_BUS_STORE
    } dbk_op_e;

    typedef enum logic [3:0] {
        S_IDLE, S_KEY_SEND, S_INFO_REQ, S_INFO_RECV, S_RST_ON, S_RST_OFF,
        S_POLL_REQ, S_POLL_WAIT, S_ROW_WRITE, S_FINAL_WR, S_KEYCLR_WR, S_NVM_WR
    } dbk_state_e;

    typedef struct packed {
        logic        valid;
        dbk_op_e     op;
        logic [15:0] addr;
        logic [7:0]  data;
    } dbk_link_req_s;

    typedef struct packed {
        logic       accept;
        logic       rvalid;
        logic [7:0] rdata;
    } dbk_link_rsp_s;

    typedef struct packed {
        logic        hsel;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic [31:0] haddr;
        logic [31:0] hwdata;
        logic        hready;
    } dbk_ahb_req_s;

    typedef struct packed {
        logic        hreadyout;
        logic [31:0] hrdata;
        logic        hresp;
    } dbk_ahb_rsp_s;

endpackage

// File: rtl/dbk_sequencer.sv
// debugger-side key unlock and programming sequencer with an AHB-Lite register slave
// ==========================================================
`timescale 1ns/1ps

module dbk_sequencer
    import dbk_pkg::*;
(
    input  wire logic          CORE_CLK,
    input  wire logic          RESET,
    input  wire dbk_ahb_req_s  AHB_REQ,
    output dbk_ahb_rsp_s       AHB_RSP,
    output dbk_link_req_s      LINK_REQ,
    input  wire dbk_link_rsp_s LINK_RSP
);

    // ==========================================================
    // state
    typedef struct packed {
        dbk_state_e              st;
        dbk_cmd_e                seq;
        logic                    late;
        logic [5:0]              idx;
        dbk_link_req_s           req;
        dbk_ahb_rsp_s            ahb;
        logic                    a_wr;
        logic                    a_rd;
        logic [5:0]              a_idx;
        logic                    busy;
        logic                    done;
        logic                    prog_ready;
        logic [7:0]              sys_status;
        logic [3:0][3:0][7:0]    info;
        logic [15:0][3:0][7:0]   row;
        logic                    nvm_pend;
        logic [15:0]             nvm_addr;
        logic [7:0]              nvm_data;
    } dbk_regs_s;

    dbk_regs_s r;
    dbk_regs_s next_r;

    assign AHB_RSP  = r.ahb;
    assign LINK_REQ = r.req;

    // ==========================================================
    // helpers
    function automatic dbk_link_req_s mk_req(dbk_op_e op, logic [15:0] addr, logic [7:0] data);
        dbk_link_req_s q;
        q.valid = 1'b1;
        q.op    = op;
        q.addr  = addr;
        q.data  = data;
        return q;
    endfunction

    function automatic logic [7:0] key_byte(dbk_cmd_e seq, logic [2:0] n);
        logic [63:0] k;
        case (seq)
            CMD_ERASE:      k = KEY_ERASE;
            CMD_PROG_ENTER: k = KEY_PROGRAM;
            default:        k = KEY_USER_ROW;
        endcase
        return k[{n, 3'b000} +: 8];
    endfunction

    function automatic logic [31:0] read_mux(dbk_regs_s s);
        logic [31:0] d;
        d = 32'h0000_0000;
        if (s.a_idx == REG_CTRL) begin
            d = {29'h0, s.seq};
        end else if (s.a_idx == REG_STATUS) begin
            d[ST_BUSY_POS]  = s.busy;
            d[ST_DONE_POS]  = s.done;
            d[ST_READY_POS] = s.prog_ready;
        end else if (s.a_idx == REG_NVM_WRITE) begin
            d = {7'h0, s.nvm_pend, s.nvm_data, s.nvm_addr};
        end else if (s.a_idx == REG_SYS_COPY) begin
            d = {24'h0, s.sys_status};
        end else if (s.a_idx[5:2] == REG_INFO_BASE[5:2]) begin
            d = s.info[s.a_idx[1:0]];
        end else if (s.a_idx[5:4] == REG_ROW_BASE[5:4]) begin
            d = s.row[s.a_idx[3:0]];
        end
        return d;
    endfunction

    logic accepted;
    logic poll_met;
    logic [7:0] rst_data;

    assign accepted = r.req.valid && LINK_RSP.accept;
    assign rst_data = (r.st == S_RST_ON) ? RESET_SIGNATURE : RESET_RELEASE;

    // ==========================================================
    // poll condition per sequence
    always_comb begin
        case (r.seq)
            CMD_ERASE:      poll_met = !LINK_RSP.rdata[LOCKED_POS];
            CMD_PROG_ENTER: poll_met = LINK_RSP.rdata[NVM_PROG_POS];
            default:        poll_met = LINK_RSP.rdata[ROW_PROG_POS] ^ r.late;
        endcase
    end

    // ==========================================================
    // next state
    always_comb begin
        dbk_cmd_e cmd;
        next_r = r;
        cmd    = dbk_cmd_e'(AHB_REQ.hwdata[2:0]);

        // ------------------------------------------------------
        // bus slave: one wait state on reads so data is never stale
        next_r.a_wr = 1'b0;
        if (r.a_rd) begin
            next_r.ahb.hrdata    = read_mux(r);
            next_r.ahb.hreadyout = 1'b1;
            next_r.a_rd          = 1'b0;
        end else if (AHB_REQ.hsel && AHB_REQ.htrans[1] && r.ahb.hreadyout) begin
            next_r.a_idx = AHB_REQ.haddr[7:2];
            next_r.a_wr  = AHB_REQ.hwrite;
            next_r.a_rd  = !AHB_REQ.hwrite;
            next_r.ahb.hreadyout = AHB_REQ.hwrite;
        end

        if (r.a_wr) begin
            if (r.a_idx == REG_CTRL && !r.busy && !r.nvm_pend) begin
                // finishing is only legal once programming was entered
                if (cmd != CMD_NONE && (cmd != CMD_PROG_FINISH || r.prog_ready)) begin
                    next_r.seq  = cmd;
                    next_r.busy = 1'b1;
                    next_r.late = 1'b0;
                    next_r.idx  = 6'h00;
                    case (cmd)
                        CMD_INFO_FULL, CMD_INFO_FAMILY: next_r.st = S_INFO_REQ;
                        CMD_PROG_FINISH:                next_r.st = S_RST_ON;
                        default:                        next_r.st = S_KEY_SEND;
                    endcase
                end
            end else if (r.a_idx == REG_STATUS && AHB_REQ.hwdata[ST_DONE_POS]) begin
                next_r.done = 1'b0;
            end else if (r.a_idx == REG_NVM_WRITE && r.prog_ready && !r.nvm_pend && !r.busy) begin
                next_r.nvm_addr = AHB_REQ.hwdata[15:0];
                next_r.nvm_data = AHB_REQ.hwdata[23:16];
                next_r.nvm_pend = 1'b1;
            end else if (r.a_idx[5:4] == REG_ROW_BASE[5:4] && !r.busy) begin
                next_r.row[r.a_idx[3:0]] = AHB_REQ.hwdata;
            end
        end

        // ------------------------------------------------------
        // link sequencer; a request stands until the device accepts it
        if (accepted) begin
            next_r.req.valid = 1'b0;
        end
        case (r.st)
            S_IDLE: begin
                // queued NVM bus stores only while programming is granted
                if (r.nvm_pend && !r.busy) begin
                    next_r.st = S_NVM_WR;
                end
            end
            S_NVM_WR: begin
                if (!r.req.valid) begin
                    next_r.req = mk_req(OP_BUS_STORE, r.nvm_addr, r.nvm_data);
                end else if (accepted) begin
                    next_r.nvm_pend = 1'b0;
                    next_r.st       = S_IDLE;
                end
            end
            S_KEY_SEND: begin
                if (!r.req.valid) begin
                    next_r.req = mk_req(OP_KEY, {13'h0, r.idx[2:0]},
                                        key_byte(r.seq, r.idx[2:0]));
                end else if (accepted) begin
                    next_r.idx = r.idx + 6'h01;
                    if (r.idx[2:0] == 3'h7) begin
                        next_r.st  = S_RST_ON;
                        next_r.idx = 6'h00;
                    end
                end
            end
            S_INFO_REQ: begin
                // byte count selects full block or family only
                if (!r.req.valid) begin
                    next_r.req = mk_req(OP_INFO, 16'h0000, (r.seq == CMD_INFO_FULL) ?
                                        INFO_FULL_BYTES : INFO_FAMILY_BYTES);
                end else if (accepted) begin
                    next_r.st  = S_INFO_RECV;
                    next_r.idx = 6'h00;
                end
            end
            S_INFO_RECV: begin
                if (LINK_RSP.rvalid) begin
                    // byte n of the block lands at byte n of the window
                    next_r.info[r.idx[3:2]][r.idx[1:0]] = LINK_RSP.rdata;
                    next_r.idx = r.idx + 6'h01;
                    if ({2'b00, r.idx} == ((r.seq == CMD_INFO_FULL) ?
                                           INFO_FULL_BYTES : INFO_FAMILY_BYTES) - 8'h01) begin
                        next_r.st   = S_IDLE;
                        next_r.busy = 1'b0;
                        next_r.done = 1'b1;
                    end
                end
            end
            S_RST_ON, S_RST_OFF: begin
                if (!r.req.valid) begin
                    next_r.req = mk_req(OP_CS_STORE, {12'h0, CS_RESET_REQ}, rst_data);
                end else if (accepted) begin
                    if (r.st == S_RST_ON) begin
                        next_r.st = S_RST_OFF;
                    end else if (r.seq == CMD_PROG_FINISH || r.late) begin
                        next_r.st         = S_IDLE;
                        next_r.busy       = 1'b0;
                        next_r.done       = 1'b1;
                        next_r.prog_ready = (r.seq == CMD_PROG_FINISH) ? 1'b0 : r.prog_ready;
                    end else begin
                        next_r.st = S_POLL_REQ;
                    end
                end
            end
            S_POLL_REQ: begin
                if (!r.req.valid) begin
                    next_r.req = mk_req(OP_CS_LOAD, {12'h0, CS_SYS_STATUS}, 8'h00);
                end else if (accepted) begin
                    next_r.st = S_POLL_WAIT;
                end
            end
            S_POLL_WAIT: begin
                if (LINK_RSP.rvalid) begin
                    next_r.sys_status = LINK_RSP.rdata;
                    next_r.st         = S_POLL_REQ;
                    if (poll_met) begin
                        next_r.idx = 6'h00;
                        if (r.seq == CMD_USER_ROW) begin
                            next_r.st = r.late ? S_KEYCLR_WR : S_ROW_WRITE;
                        end else begin
                            next_r.st         = S_IDLE;
                            next_r.busy       = 1'b0;
                            next_r.done       = 1'b1;
                            next_r.prog_ready = (r.seq == CMD_PROG_ENTER);
                        end
                    end
                end
            end
            S_ROW_WRITE: begin
                // exactly RAM bytes 0..63, one to one
                if (!r.req.valid) begin
                    next_r.req = mk_req(OP_BUS_STORE, {10'h0, r.idx},
                                        r.row[r.idx[5:2]][r.idx[1:0]]);
                end else if (accepted) begin
                    next_r.idx = r.idx + 6'h01;
                    if (r.idx == ROW_LAST_BYTE) begin
                        next_r.st = S_FINAL_WR;
                    end
                end
            end
            S_FINAL_WR: begin
                // finalize, then wait for the flag to drop
                if (!r.req.valid) begin
                    next_r.req = mk_req(OP_CS_STORE, {12'h0, CS_SYS_CTRL}, USER_ROW_FINAL_BIT);
                end else if (accepted) begin
                    next_r.late = 1'b1;
                    next_r.st   = S_POLL_REQ;
                end
            end
            S_KEYCLR_WR: begin
                // clear the user row key before the last reset
                if (!r.req.valid) begin
                    next_r.req = mk_req(OP_CS_STORE, {12'h0, CS_KEY_STATUS}, USER_ROW_KEY_BIT);
                end else if (accepted) begin
                    next_r.st = S_RST_ON;
                end
            end
            default: begin
                next_r.st = S_IDLE;
            end
        endcase
    end

    // ==========================================================
    // register
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            r                   <= '0;
            r.st                <= S_IDLE;
            r.seq               <= CMD_NONE;
            r.ahb.hreadyout     <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RESET);

    chk_key_lsb_first: assert property (
        (r.st == S_KEY_SEND && r.req.valid && r.req.addr == 16'h0000 && r.seq == CMD_ERASE)
        |-> r.req.data == 8'h65)
        else $error("erase key not sent least byte first");

    chk_reset_assert: assert property (
        (r.st == S_RST_ON && r.req.valid) |-> (r.req.data == 8'h59 && r.req.addr == 16'h0008))
        else $error("reset request without reset signature");

    chk_reset_release: assert property (
        (r.st == S_RST_ON && accepted) |=> ##1 (r.req.valid && r.req.data == 8'h00))
        else $error("reset not released right after assertion");

    chk_erase_unlocked: assert property (
        ($rose(r.done) && r.seq == CMD_ERASE) |-> !r.sys_status[0])
        else $error("erase reported done while still locked");

    chk_prog_flag: assert property (
        $rose(r.prog_ready) |-> r.sys_status[3])
        else $error("programming granted without device flag");

    chk_row_range: assert property (
        (r.req.valid && r.req.op == OP_BUS_STORE && r.st == S_ROW_WRITE) |-> r.req.addr < 16'h0040)
        else $error("user row write outside first 64 bytes");

    chk_bus_gate: assert property (
        (r.req.valid && r.req.op == OP_BUS_STORE) |-> (r.prog_ready || r.seq == CMD_USER_ROW))
        else $error("system bus store on a part not opened");

    chk_info_size: assert property (
        (r.req.valid && r.req.op == OP_INFO)
        |-> r.req.data == ((r.seq == CMD_INFO_FULL) ? 8'h10 : 8'h08))
        else $error("info block size not 16 or 8 as asked");

    chk_final_then_poll: assert property (
        (r.st == S_FINAL_WR && accepted) |=> ##1 (r.req.valid && r.req.addr == 16'h000B))
        else $error("finalize not followed by status poll");

    cov_erase_done: cover property ($rose(r.done) && r.seq == CMD_ERASE);
    cov_info_full:  cover property ($rose(r.done) && r.seq == CMD_INFO_FULL);
    cov_row_done:   cover property ($rose(r.done) && r.seq == CMD_USER_ROW);
    cov_nvm_store:  cover property (r.st == S_NVM_WR && accepted);

endmodule

// File: verif/dbk_device_model.sv
// device-side model of the keyed debug port, behavioural
`timescale 1ns/1ps

module dbk_device_model
    import dbk_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire dbk_link_req_s req,
    output dbk_link_rsp_s      rsp,
    input  wire logic          start_locked,
    input  wire logic          slow
);
    // arbitrary ascii content, no real part
    localparam logic [127:0] INFO = "fam_abc P:2D:1 3";

    logic [63:0] key;
    logic        erase_key, prog_key, row_key, locked;
    logic        sysrst, nvm_prog, row_prog, acc, rv;
    logic [7:0]  rd, last_n;
    logic [1:0]  cnt;
    logic [7:0]  q[$];
    logic [7:0]  ram[64];
    logic [7:0]  urow[64];
    logic [7:0]  nvm[65536];
    logic        lk;
    logic        bod_forced;

    assign rsp = '{accept: acc, rvalid: rv, rdata: rd};
    assign lk  = locked && !erase_key;

    always @(posedge clk) begin
        cnt <= cnt + 2'd1;
        // slow mode stalls accept to every fourth cycle
        acc <= req.valid && !acc && (!slow || cnt == 2'h3);
        rv  <= 1'b0;
        // released data line toggles, never holds a stale byte
        rd  <= ~rd;
        if (q.size() > 0 && !rv) begin
            rv <= 1'b1;
            rd <= q.pop_front();
        end
        if (rst) begin
            {erase_key, prog_key, row_key, sysrst, nvm_prog, row_prog, bod_forced} <= 7'h00;
            {acc, rv, rd, last_n, key, cnt} <= '0;
            locked <= start_locked;
            q.delete();
        end else if (req.valid && acc) begin
            case (req.op)
                OP_KEY: begin
                    key <= {req.data, key[63:8]};
                    if (req.addr[2:0] == 3'h7) begin
                        if ({req.data, key[63:8]} == KEY_ERASE) erase_key <= 1'b1;
                        if ({req.data, key[63:8]} == KEY_PROGRAM) prog_key <= 1'b1;
                        if ({req.data, key[63:8]} == KEY_USER_ROW) row_key <= 1'b1;
                    end
                end
                OP_INFO: begin
                    last_n <= req.data;
                    for (int i = 0; i < req.data; i++) q.push_back(INFO[127-8*i -: 8]);
                end
                OP_CS_LOAD: begin
                    if (req.addr[3:0] == CS_SYS_STATUS)
                        q.push_back({4'h0, nvm_prog, row_prog, 1'b0, locked});
                    else if (req.addr[3:0] == CS_KEY_STATUS)
                        q.push_back({2'h0, row_key, prog_key, erase_key, 3'h0});
                    else
                        q.push_back({7'h00, sysrst});
                end
                OP_CS_STORE: begin
                    if (req.addr[3:0] == CS_RESET_REQ) begin
                        sysrst <= (req.data == RESET_SIGNATURE);
                        // brown-out held active while erase runs
                        bod_forced <= erase_key && (req.data == RESET_SIGNATURE);
                        if (sysrst && req.data != RESET_SIGNATURE) begin
                            if (erase_key) begin
                                locked    <= 1'b0;
                                erase_key <= 1'b0;
                            end
                            if (nvm_prog) begin
                                nvm_prog <= 1'b0;
                                prog_key <= 1'b0;
                            end else if (prog_key && !lk) nvm_prog <= 1'b1;
                            if (row_key && lk) row_prog <= 1'b1;
                        end
                    end
                    if (req.addr[3:0] == CS_SYS_CTRL && req.data[1] && row_prog) begin
                        urow     <= ram;
                        row_prog <= 1'b0;
                    end
                    // key bit write drops user row key
                    if (req.addr[3:0] == CS_KEY_STATUS && req.data[5]) row_key <= 1'b0;
                end
                OP_BUS_STORE: begin
                    if (row_prog) begin
                        if (req.addr < 16'h0040) ram[req.addr[5:0]] <= req.data;
                    end else if (!locked) nvm[req.addr] <= req.data;
                end
                default: ;
            endcase
        end
    end
endmodule

// File: verif/dbk_sequencer_test.sv
// self-checking testbench of the key unlock sequencer
`timescale 1ns/1ps

module dbk_sequencer_test
    import dbk_pkg::*;
;
    localparam logic [127:0] INFO = "fam_abc P:2D:1 3";

    logic          clk = 1'b0;
    logic          rst = 1'b1;
    logic          slow = 1'b0;
    dbk_ahb_req_s  ahb = '0;
    dbk_ahb_req_s  req;
    dbk_ahb_rsp_s  rsp;
    dbk_link_req_s lreq;
    dbk_link_rsp_s lrsp;
    int            fails = 0;
    int            samples_checked = 0;
    int            seed = 88;
    logic [31:0]   r;
    logic [7:0]    rowq[$];

    initial forever #2.5 clk = ~clk;

    always_comb begin
        req        = ahb;
        req.hready = rsp.hreadyout;
    end

    dbk_sequencer DUT (
        .CORE_CLK (clk),
        .RESET    (rst),
        .AHB_REQ  (req),
        .AHB_RSP  (rsp),
        .LINK_REQ (lreq),
        .LINK_RSP (lrsp)
    );

    dbk_device_model DEV (
        .clk          (clk),
        .rst          (rst),
        .req          (lreq),
        .rsp          (lrsp),
        .start_locked (1'b1),
        .slow         (slow)
    );

    // ==========================================================
    // tasks
    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        ahb.hsel   <= 1'b1;
        ahb.htrans <= 2'b10;
        ahb.hwrite <= w;
        ahb.hsize  <= 3'h2;
        ahb.haddr  <= {24'h000000, a};
        do begin @(posedge clk); n++; end while (rsp.hreadyout !== 1'b1 && n < 100);
        ahb.htrans <= 2'b00;
        ahb.hwdata <= d;
        do begin @(posedge clk); n++; end while (rsp.hreadyout !== 1'b1 && n < 100);
        r = rsp.hrdata;
        if (n >= 100) begin
            fails++;
            end_sim();
        end
    endtask

    // start a command, wait for done, then clear done
    task automatic run(input logic [2:0] c, input string n);
        int k;
        k = 0;
        xfer(1'b1, 8'h00, {29'h0, c});
        do begin xfer(1'b0, 8'h04, 32'h0); k++; end while (r[1] !== 1'b1 && k < 5000);
        chk({n, " done"}, 32'h1, {31'h0, r[1]});
        chk({n, " busy"}, 32'h0, {31'h0, r[0]});
        xfer(1'b1, 8'h04, 32'h2);
        $display("test %s done", n);
    endtask

    function automatic logic [7:0] ib(input int b);
        return INFO[127-8*b -: 8];
    endfunction

    initial begin
        repeat (50000) @(posedge clk);
        fails++;
        end_sim();
    end

    // ==========================================================
    // main sequence
    initial begin
        int          w, b, k, m;
        logic [31:0] d;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        xfer(1'b0, 8'h04, 32'h0);
        chk("status reset", 32'h0, r);
        xfer(1'b0, 8'h80, 32'h0);
        chk("unmapped", 32'h0, r);
        // info block, full then family with a stalling partner
        for (m = 0; m < 2; m++) begin
            slow <= m[0];
            run(m ? 3'h2 : 3'h1, m ? "info family" : "info full");
            chk("info size", m ? 32'h8 : 32'h10, {24'h0, DEV.last_n});
            for (w = 0; w < (m ? 2 : 4); w++) begin
                xfer(1'b0, 8'h10 + 8'(4 * w), 32'h0);
                chk("info word", {ib(4*w+3), ib(4*w+2), ib(4*w+1), ib(4*w)}, r);
            end
        end
        // user row on the locked part
        for (w = 0; w < 16; w++) begin
            d = $random(seed);
            for (b = 0; b < 4; b++) rowq.push_back(d[8*b +: 8]);
            xfer(1'b1, 8'h40 + 8'(4 * w), d);
        end
        run(3'h6, "user row");
        for (b = 0; b < 64; b++) chk("row byte", {24'h0, rowq[b]}, {24'h0, DEV.urow[b]});
        chk("row key", 32'h0, {31'h0, DEV.row_key});
        chk("still locked", 32'h1, {31'h0, DEV.locked});
        chk("reset held", 32'h0, {31'h0, DEV.sysrst});
        slow <= 1'b0;
        // erase unlocks
        run(3'h3, "erase");
        chk("locked", 32'h0, {31'h0, DEV.locked});
        chk("erase key", 32'h0, {31'h0, DEV.erase_key});
        xfer(1'b0, 8'h0C, 32'h0);
        chk("sys status", 32'h0, {31'h0, r[0]});
        // programming
        run(3'h4, "prog enter");
        xfer(1'b0, 8'h04, 32'h0);
        chk("prog ready", 32'h1, {31'h0, r[2]});
        chk("prog flag", 32'h1, {31'h0, DEV.nvm_prog});
        for (w = 0; w < 3; w++) begin
            d = $random(seed);
            xfer(1'b1, 8'h08, {8'h00, d[23:0]});
            k = 0;
            do begin xfer(1'b0, 8'h08, 32'h0); k++; end while (r[24] !== 1'b0 && k < 100);
            chk("nvm byte", {24'h0, d[23:16]}, {24'h0, DEV.nvm[d[15:0]]});
        end
        run(3'h5, "prog finish");
        xfer(1'b0, 8'h04, 32'h0);
        chk("prog ready off", 32'h0, {31'h0, r[2]});
        chk("prog key", 32'h0, {31'h0, DEV.prog_key});
        end_sim();
    end
endmodule
